// [design/gpio_pkg.sv]
// shared constants for the port pin block
package gpio_pkg;

	localparam int NUM_PORTS = 7;
	localparam int DATA_W    = 8;
	localparam int IDX_W     = 7;
	localparam int ADDR_W    = 9;

	localparam int PORT_A = 0;
	localparam int PORT_B = 1;
	localparam int PORT_C = 2;
	localparam int PORT_D = 3;
	localparam int PORT_E = 4;
	localparam int PORT_F = 5;
	localparam int PORT_G = 6;

	// register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] LATCH_IDX [NUM_PORTS] = '{
		7'h3b, 7'h38, 7'h35, 7'h32, 7'h23, 7'h62, 7'h65};
	localparam logic [IDX_W-1:0] DIR_IDX [NUM_PORTS] = '{
		7'h3a, 7'h37, 7'h34, 7'h31, 7'h22, 7'h61, 7'h64};
	localparam logic [IDX_W-1:0] PIN_IDX [NUM_PORTS] = '{
		7'h39, 7'h36, 7'h33, 7'h30, 7'h21, 7'h20, 7'h63};
	localparam logic [IDX_W-1:0] STATUS_IDX = 7'h70;

	// implemented bits per port
	localparam logic [DATA_W-1:0] PORT_MASK [NUM_PORTS] = '{
		8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f};

	localparam logic [DATA_W-1:0] LATCH_RST = 8'h00;
	localparam logic [DATA_W-1:0] DIR_RST   = 8'h00;
	localparam logic [DATA_W-1:0] SYNC_RST  = 8'h00;

	// test port pins on port f
	localparam logic [DATA_W-1:0] JTAG_PU_MASK = 8'hb0;
	localparam int                TDO_BIT      = 6;

	// port g in legacy mode
	localparam logic [DATA_W-1:0] G_STROBE_MASK = 8'h07;
	localparam logic [DATA_W-1:0] G_OSC_MASK    = 8'h18;
	localparam logic [2:0]        G_STROBE_RST  = 3'h3;

	// status register bit positions
	localparam int ST_LEGACY = 0;
	localparam int ST_PROG   = 1;
	localparam int ST_JTAG   = 2;
	localparam int ST_ADC    = 3;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} bus_state_e;

endpackage

// [design/strap_capture.sv]
// fuse and programming-entry pin capture
`timescale 1ns/1ps
`default_nettype none
module strap_capture (
	input  wire logic ref_clk_i,
	input  wire logic rst_n_i,
	input  wire logic legacy_fuse_i,
	input  wire logic programming_entry_pin_i,
	output logic      legacy_mode_o,
	output logic      prog_mode_o
);
	// no reset on the chains: the fuse level must reach the pads while reset holds
	logic fuse_meta_reg;
	logic fuse_sync_reg;
	logic pen_meta_reg;
	logic pen_sync_reg;
	logic captured_reg;
	logic prog_reg;

	always_ff @(posedge ref_clk_i) begin
		fuse_meta_reg <= legacy_fuse_i;
		fuse_sync_reg <= fuse_meta_reg;
		pen_meta_reg  <= programming_entry_pin_i;
		pen_sync_reg  <= pen_meta_reg;
	end

	// pin is looked at once, first edge after release; ignored afterwards
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			captured_reg <= 1'b0;
			prog_reg     <= 1'b0;
		end else if (!captured_reg) begin
			captured_reg <= 1'b1;
			prog_reg     <= ~pen_sync_reg;
		end
	end

	assign legacy_mode_o = fuse_sync_reg;
	assign prog_mode_o   = prog_reg;
endmodule // strap_capture
`default_nettype wire

// [design/port_slice.sv]
// one port: pad control and input sampling
`timescale 1ns/1ps
`default_nettype none
module port_slice (
	input  wire logic                      ref_clk_i,
	input  wire logic                      rst_n_i,
	input  wire logic [gpio_pkg::DATA_W-1:0] dir_i,
	input  wire logic [gpio_pkg::DATA_W-1:0] latch_i,
	input  wire logic [gpio_pkg::DATA_W-1:0] mask_i,
	input  wire logic [gpio_pkg::DATA_W-1:0] ovr_en_i,
	input  wire logic [gpio_pkg::DATA_W-1:0] ovr_oe_i,
	input  wire logic [gpio_pkg::DATA_W-1:0] ovr_out_i,
	input  wire logic [gpio_pkg::DATA_W-1:0] ovr_pu_i,
	input  wire logic [gpio_pkg::DATA_W-1:0] pin_i,
	output logic      [gpio_pkg::DATA_W-1:0] pin_o,
	output logic      [gpio_pkg::DATA_W-1:0] pin_oe_o,
	output logic      [gpio_pkg::DATA_W-1:0] pull_up_o,
	output logic      [gpio_pkg::DATA_W-1:0] level_o
);
	import gpio_pkg::*;

	logic [DATA_W-1:0] meta_reg;
	logic [DATA_W-1:0] sync_reg;
	logic [DATA_W-1:0] gpio_oe;
	logic [DATA_W-1:0] gpio_pu;

	// raw reset gates the pads so they float with no clock running
	assign gpio_oe = dir_i & {DATA_W{rst_n_i}};
	assign gpio_pu = ~dir_i & latch_i & {DATA_W{rst_n_i}};

	assign pin_oe_o  = mask_i & ((ovr_en_i & ovr_oe_i) | (~ovr_en_i & gpio_oe));
	assign pin_o     = mask_i & ((ovr_en_i & ovr_out_i) | (~ovr_en_i & latch_i));
	assign pull_up_o = mask_i & ((ovr_en_i & ovr_pu_i) | (~ovr_en_i & gpio_pu));

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_reg <= SYNC_RST;
			sync_reg <= SYNC_RST;
		end else begin
			meta_reg <= pin_i;
			sync_reg <= meta_reg;
		end
	end

	assign level_o = sync_reg & mask_i;
endmodule // port_slice
`default_nettype wire

// [design/port_pins.sv]
// general purpose port block: seven ports, legacy mode, avalon registers
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module port_pins (
	input  wire logic                                          ref_clk_i,
	input  wire logic                                          rst_n_i,
	// avalon-mm slave
	input  wire logic [gpio_pkg::ADDR_W-1:0]                   avs_address,
	input  wire logic                                          avs_read,
	input  wire logic                                          avs_write,
	input  wire logic [31:0]                                   avs_writedata,
	input  wire logic [3:0]                                    avs_byteenable,
	output logic      [31:0]                                   avs_readdata,
	output logic                                               avs_waitrequest,
	// board pins, port index a=0 .. g=6
	input  wire logic [gpio_pkg::NUM_PORTS-1:0][gpio_pkg::DATA_W-1:0] port_pin_i,
	output logic      [gpio_pkg::NUM_PORTS-1:0][gpio_pkg::DATA_W-1:0] port_pin_o,
	output logic      [gpio_pkg::NUM_PORTS-1:0][gpio_pkg::DATA_W-1:0] port_pin_oe_o,
	output logic      [gpio_pkg::NUM_PORTS-1:0][gpio_pkg::DATA_W-1:0] port_pull_up_o,
	// straps
	input  wire logic                                          legacy_fuse_i,
	input  wire logic                                          programming_entry_pin_i,
	output logic                                               serial_prog_mode_o,
	// on-chip neighbours, same clock
	input  wire logic                                          adc_in_use_i,
	input  wire logic                                          jtag_enable_i,
	input  wire logic                                          tap_shift_i,
	input  wire logic                                          tdo_i,
	input  wire logic                                          port_g_bit0_write_strobe_i,
	input  wire logic                                          port_g_bit1_read_strobe_i,
	input  wire logic                                          port_g_bit2_latch_enable_i
);
	import gpio_pkg::*;

	bus_state_e        bus_state_reg;
	bus_state_e        bus_state_next;
	logic [DATA_W-1:0] latch_reg [NUM_PORTS];
	logic [DATA_W-1:0] dir_reg   [NUM_PORTS];
	logic [31:0]       readdata_reg;

	logic              legacy_mode;
	logic              prog_mode;
	logic              bus_req;
	logic              wr_fire;
	logic              rd_load;
	logic              bus_idle;
	logic              bus_ack;
	logic [IDX_W-1:0]  reg_idx;
	logic              lane0;
	logic              status_hit;
	logic [NUM_PORTS-1:0] latch_hit;
	logic [NUM_PORTS-1:0] dir_hit;
	logic [NUM_PORTS-1:0] pin_hit;
	logic [NUM_PORTS-1:0] latch_wr;
	logic [NUM_PORTS-1:0] dir_wr;
	logic [DATA_W-1:0] pin_level [NUM_PORTS];
	logic [DATA_W-1:0] status_val;
	logic [DATA_W-1:0] read_val;

	logic [DATA_W-1:0] ovr_en  [NUM_PORTS];
	logic [DATA_W-1:0] ovr_oe  [NUM_PORTS];
	logic [DATA_W-1:0] ovr_out [NUM_PORTS];
	logic [DATA_W-1:0] ovr_pu  [NUM_PORTS];

	logic              f_float;
	logic [DATA_W-1:0] f_jtag_en;
	logic [DATA_W-1:0] f_jtag_oe;
	logic [DATA_W-1:0] f_jtag_out;
	logic [DATA_W-1:0] tdo_mask;
	logic [DATA_W-1:0] g_strobe;
	logic [DATA_W-1:0] g_strobe_val;

	strap_capture u_strap (
		.ref_clk_i               (ref_clk_i),
		.rst_n_i                 (rst_n_i),
		.legacy_fuse_i           (legacy_fuse_i),
		.programming_entry_pin_i (programming_entry_pin_i),
		.legacy_mode_o           (legacy_mode),
		.prog_mode_o             (prog_mode)
	);

	assign serial_prog_mode_o = prog_mode;

	// bus: one wait cycle on every access, read data set up meanwhile
	assign bus_idle        = (bus_state_reg == BUS_IDLE);
	assign bus_ack         = (bus_state_reg == BUS_ACK);
	assign bus_req         = avs_read | avs_write;
	assign avs_waitrequest = bus_req & bus_idle;
	assign wr_fire         = avs_write & bus_ack;
	assign rd_load         = avs_read & bus_idle;
	assign reg_idx         = avs_address[ADDR_W-1:2];
	assign lane0           = avs_byteenable[0];
	assign status_hit      = (reg_idx == STATUS_IDX);
	assign avs_readdata    = readdata_reg;

	always_comb begin
		bus_state_next = bus_state_reg;
		case (bus_state_reg)
			BUS_IDLE: begin
				if (bus_req) begin
					bus_state_next = BUS_ACK;
				end
			end
			BUS_ACK: begin
				bus_state_next = BUS_IDLE;
			end
			default: begin
				bus_state_next = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_state_reg <= BUS_IDLE;
		end else begin
			bus_state_reg <= bus_state_next;
		end
	end

	always_comb begin
		status_val            = 8'h00;
		status_val[ST_LEGACY] = legacy_mode;
		status_val[ST_PROG]   = prog_mode;
		status_val[ST_JTAG]   = jtag_enable_i;
		status_val[ST_ADC]    = adc_in_use_i;
	end

	// read mux; unmapped and reserved answer zero
	always_comb begin
		read_val = 8'h00;
		if (status_hit) begin
			read_val = status_val;
		end
		// output latches
		else if (latch_hit[PORT_A]) begin
			read_val = latch_reg[PORT_A];
		end
		else if (latch_hit[PORT_B]) begin
			read_val = latch_reg[PORT_B];
		end
		else if (latch_hit[PORT_C]) begin
			read_val = latch_reg[PORT_C];
		end
		else if (latch_hit[PORT_D]) begin
			read_val = latch_reg[PORT_D];
		end
		else if (latch_hit[PORT_E]) begin
			read_val = latch_reg[PORT_E];
		end
		else if (latch_hit[PORT_F]) begin
			read_val = latch_reg[PORT_F];
		end
		else if (latch_hit[PORT_G]) begin
			read_val = latch_reg[PORT_G];
		end
		// direction registers
		else if (dir_hit[PORT_A]) begin
			read_val = dir_reg[PORT_A];
		end
		else if (dir_hit[PORT_B]) begin
			read_val = dir_reg[PORT_B];
		end
		else if (dir_hit[PORT_C]) begin
			read_val = dir_reg[PORT_C];
		end
		else if (dir_hit[PORT_D]) begin
			read_val = dir_reg[PORT_D];
		end
		else if (dir_hit[PORT_E]) begin
			read_val = dir_reg[PORT_E];
		end
		else if (dir_hit[PORT_F]) begin
			read_val = dir_reg[PORT_F];
		end
		else if (dir_hit[PORT_G]) begin
			read_val = dir_reg[PORT_G];
		end
		// synchronised pin levels
		else if (pin_hit[PORT_A]) begin
			read_val = pin_level[PORT_A];
		end
		else if (pin_hit[PORT_B]) begin
			read_val = pin_level[PORT_B];
		end
		else if (pin_hit[PORT_C]) begin
			read_val = pin_level[PORT_C];
		end
		else if (pin_hit[PORT_D]) begin
			read_val = pin_level[PORT_D];
		end
		else if (pin_hit[PORT_E]) begin
			read_val = pin_level[PORT_E];
		end
		else if (pin_hit[PORT_F]) begin
			read_val = pin_level[PORT_F];
		end
		else if (pin_hit[PORT_G]) begin
			read_val = pin_level[PORT_G];
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			readdata_reg <= 32'h0000_0000;
		end else if (rd_load) begin
			readdata_reg <= {24'h00_0000, read_val};
		end
	end

	// legacy port f pads: shared float decision and test port takeover
	assign f_float    = adc_in_use_i | legacy_mode;
	assign tdo_mask   = 8'h01 << TDO_BIT;
	assign f_jtag_en  = jtag_enable_i ? (JTAG_PU_MASK | tdo_mask) : 8'h00;
	assign f_jtag_oe  = tdo_mask & {DATA_W{tap_shift_i & rst_n_i}};
	assign f_jtag_out = tdo_mask & {DATA_W{tdo_i}};

	// strobes idle at the reset pattern without needing the clock
	assign g_strobe = {5'h00, port_g_bit2_latch_enable_i, port_g_bit1_read_strobe_i,
		port_g_bit0_write_strobe_i};
	assign g_strobe_val = rst_n_i ? g_strobe : {5'h00, G_STROBE_RST};

	genvar gp;
	generate
		for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
			assign latch_hit[gp] = (reg_idx == LATCH_IDX[gp]);
			assign dir_hit[gp]   = (reg_idx == DIR_IDX[gp]);
			assign pin_hit[gp]   = (reg_idx == PIN_IDX[gp]);
			assign latch_wr[gp]  = wr_fire & lane0 & latch_hit[gp];
			assign dir_wr[gp]    = wr_fire & lane0 & dir_hit[gp];

			// unimplemented bits stay zero whatever software writes
			always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					latch_reg[gp] <= LATCH_RST;
					dir_reg[gp]   <= DIR_RST;
				end else begin
					if (latch_wr[gp]) begin
						latch_reg[gp] <= avs_writedata[DATA_W-1:0] & PORT_MASK[gp];
					end
					if (dir_wr[gp]) begin
						dir_reg[gp] <= avs_writedata[DATA_W-1:0] & PORT_MASK[gp];
					end
				end
			end

			if (gp == PORT_C) begin : g_ovr_c
				// legacy: fixed output, pads never released in reset
				assign ovr_en[gp]  = {DATA_W{legacy_mode}};
				assign ovr_oe[gp]  = {DATA_W{1'b1}};
				assign ovr_out[gp] = latch_reg[gp];
				assign ovr_pu[gp]  = 8'h00;
			end else if (gp == PORT_F) begin : g_ovr_f
				// test port pull-ups hold even while reset is low
				assign ovr_en[gp]  = f_jtag_en | {DATA_W{f_float}};
				assign ovr_oe[gp]  = f_jtag_oe & f_jtag_en;
				assign ovr_out[gp] = f_jtag_out;
				assign ovr_pu[gp]  = f_jtag_en & JTAG_PU_MASK;
			end else if (gp == PORT_G) begin : g_ovr_g
				// legacy: strobes plus oscillator pins, no gpio use
				assign ovr_en[gp]  = {DATA_W{legacy_mode}} & PORT_MASK[gp];
				assign ovr_oe[gp]  = G_STROBE_MASK;
				assign ovr_out[gp] = g_strobe_val & G_STROBE_MASK;
				assign ovr_pu[gp]  = 8'h00 & G_OSC_MASK;
			end else begin : g_ovr_none
				assign ovr_en[gp]  = 8'h00;
				assign ovr_oe[gp]  = 8'h00;
				assign ovr_out[gp] = 8'h00;
				assign ovr_pu[gp]  = 8'h00;
			end

			port_slice u_slice (
				.ref_clk_i  (ref_clk_i),
				.rst_n_i    (rst_n_i),
				.dir_i      (dir_reg[gp]),
				.latch_i    (latch_reg[gp]),
				.mask_i     (PORT_MASK[gp]),
				.ovr_en_i   (ovr_en[gp]),
				.ovr_oe_i   (ovr_oe[gp]),
				.ovr_out_i  (ovr_out[gp]),
				.ovr_pu_i   (ovr_pu[gp]),
				.pin_i      (port_pin_i[gp]),
				.pin_o      (port_pin_o[gp]),
				.pin_oe_o   (port_pin_oe_o[gp]),
				.pull_up_o  (port_pull_up_o[gp]),
				.level_o    (pin_level[gp])
			);
		end
	endgenerate

endmodule // port_pins
`default_nettype wire

// [verification/port_pins_sva.sv]
// concurrent checks on the port pin block ports
`timescale 1ns/1ps
`default_nettype none
module port_pins_sva (
	input wire logic						ref_clk_i,
	input wire logic						rst_n_i,
	input wire logic [gpio_pkg::ADDR_W-1:0]				avs_address,
	input wire logic						avs_read,
	input wire logic						avs_write,
	input wire logic [31:0]						avs_writedata,
	input wire logic [3:0]						avs_byteenable,
	input wire logic						avs_waitrequest,
	input wire logic [gpio_pkg::NUM_PORTS-1:0][gpio_pkg::DATA_W-1:0]	port_pin_o,
	input wire logic [gpio_pkg::NUM_PORTS-1:0][gpio_pkg::DATA_W-1:0]	port_pin_oe_o,
	input wire logic [gpio_pkg::NUM_PORTS-1:0][gpio_pkg::DATA_W-1:0]	port_pull_up_o,
	input wire logic						legacy_fuse_i,
	input wire logic						jtag_enable_i,
	input wire logic						tap_shift_i,
	input wire logic						serial_prog_mode_o,
	input wire logic						port_g_bit0_write_strobe_i,
	input wire logic						port_g_bit1_read_strobe_i,
	input wire logic						port_g_bit2_latch_enable_i
);
	import gpio_pkg::*;
	logic [2:0]	fuse_age = 3'h0;
	logic		fuse_q = 1'b0;
	logic		fuse_ok;
	// fuse sync has no reset, so legacy pins are judged once it settled
	always_ff @(posedge ref_clk_i) begin
		fuse_q <= legacy_fuse_i;
		if (fuse_q != legacy_fuse_i) fuse_age <= 3'h0;
		else if (fuse_age != 3'h7) fuse_age <= fuse_age + 3'h1;
	end
	assign fuse_ok = (fuse_age > 3'h3) && (fuse_q == legacy_fuse_i);
	// reset-time pin checks carry no disable: they must hold inside reset
	a_reset_floats: assert property (@(posedge ref_clk_i) !rst_n_i && fuse_ok |->
		{port_pin_oe_o[4:3], port_pin_oe_o[1:0], port_pin_oe_o[5]} == 40'h0 &&
		(legacy_fuse_i || port_pin_oe_o[2] == 8'h0) &&
		(port_pin_oe_o[6] & (legacy_fuse_i ? 8'hf8 : 8'hff)) == 8'h0)
		else $error("pin driven during reset");
	a_legacy_port_c: assert property (@(posedge ref_clk_i) fuse_ok && legacy_fuse_i |->
		port_pin_oe_o[2] == 8'hff && (rst_n_i || port_pin_o[2] == 8'h00))
		else $error("port c not output only");
	a_legacy_strobes: assert property (@(posedge ref_clk_i)
		!rst_n_i && fuse_ok && legacy_fuse_i |->
		port_pin_oe_o[6][2:0] == 3'h7 && port_pin_o[6][2:0] == G_STROBE_RST)
		else $error("strobe reset levels wrong");
	a_legacy_alt: assert property (@(posedge ref_clk_i)
		rst_n_i && fuse_ok && legacy_fuse_i |-> port_pin_oe_o[6][2:0] == 3'h7 &&
		port_pin_o[6][2:0] == {port_g_bit2_latch_enable_i, port_g_bit1_read_strobe_i,
		port_g_bit0_write_strobe_i}) else $error("port g strobes not passed");
	a_legacy_osc: assert property (@(posedge ref_clk_i) fuse_ok && legacy_fuse_i |->
		((port_pin_oe_o[6] | port_pull_up_o[6]) & G_OSC_MASK) == 8'h0)
		else $error("oscillator pins used as logic");
	a_legacy_f_in: assert property (@(posedge ref_clk_i)
		fuse_ok && legacy_fuse_i && !jtag_enable_i |-> port_pin_oe_o[5] == 8'h0)
		else $error("port f drives in legacy mode");
	a_jtag_pullups: assert property (@(posedge ref_clk_i) jtag_enable_i |->
		(port_pull_up_o[5] & JTAG_PU_MASK) == JTAG_PU_MASK &&
		(port_pin_oe_o[5] & JTAG_PU_MASK) == 8'h0) else $error("test pins not pulled up");
	a_tdo_float: assert property (@(posedge ref_clk_i)
		jtag_enable_i && !(tap_shift_i && rst_n_i) |-> !port_pin_oe_o[5][TDO_BIT])
		else $error("tdo driven outside shift");
	a_one_wait: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest held too long");
	a_dir_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		avs_write && !avs_waitrequest && avs_byteenable[0] &&
		avs_address[8:2] == DIR_IDX[PORT_A] |=>
		port_pin_oe_o[PORT_A] == $past(avs_writedata[7:0])) else $error("dir write lost");
	a_prog_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		$past(rst_n_i) |=> $stable(serial_prog_mode_o)) else $error("prog mode moved");
endmodule // port_pins_sva
bind port_pins port_pins_sva i_port_pins_sva (.ref_clk_i, .rst_n_i, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .port_pin_o,
	.port_pin_oe_o, .port_pull_up_o, .legacy_fuse_i, .jtag_enable_i, .tap_shift_i,
	.serial_prog_mode_o, .port_g_bit0_write_strobe_i, .port_g_bit1_read_strobe_i,
	.port_g_bit2_latch_enable_i);
`default_nettype wire

// [verification/board_model.sv]
// board circuitry on the port pins
`timescale 1ns/1ps
`default_nettype none
module board_model (
	input  wire logic							ref_clk_i,
	input  wire logic [gpio_pkg::NUM_PORTS-1:0][gpio_pkg::DATA_W-1:0]	out_i,
	input  wire logic [gpio_pkg::NUM_PORTS-1:0][gpio_pkg::DATA_W-1:0]	oe_i,
	input  wire logic [gpio_pkg::NUM_PORTS-1:0][gpio_pkg::DATA_W-1:0]	pu_i,
	input  wire logic [gpio_pkg::NUM_PORTS-1:0][gpio_pkg::DATA_W-1:0]	ext_i,
	input  wire logic [gpio_pkg::NUM_PORTS-1:0][gpio_pkg::DATA_W-1:0]	ext_en_i,
	output logic      [gpio_pkg::NUM_PORTS-1:0][gpio_pkg::DATA_W-1:0]	level_o
);
	import gpio_pkg::*;
	logic flip = 1'b0;
	// an open pin wanders, so it never reads as a stable guess
	always_ff @(posedge ref_clk_i) flip <= ~flip;
	assign level_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_i) |
		(~oe_i & ~ext_en_i & (pu_i | {(NUM_PORTS*DATA_W){flip}}));
endmodule // board_model
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench for the port pin block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import gpio_pkg::*;
	typedef logic [NUM_PORTS-1:0][DATA_W-1:0] pins_t;
	logic [ADDR_W-1:0]	avs_address;
	logic [31:0]		avs_writedata, avs_readdata;
	logic [3:0]		avs_byteenable;
	logic			ref_clk_i, rst_n_i, avs_read, avs_write, avs_waitrequest;
	pins_t			port_pin_i, port_pin_o, port_pin_oe_o, port_pull_up_o, ext, ext_en;
	logic			legacy_fuse_i, programming_entry_pin_i, serial_prog_mode_o;
	logic			adc_in_use_i, jtag_enable_i, tap_shift_i, tdo_i;
	logic			port_g_bit0_write_strobe_i, port_g_bit1_read_strobe_i;
	logic			port_g_bit2_latch_enable_i;
	int			num_errors = 0;
	int			total_checks = 0;
	int			cycles = 0;
	port_pins i_port_pins (.ref_clk_i, .rst_n_i, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .port_pin_i,
		.port_pin_o, .port_pin_oe_o, .port_pull_up_o, .legacy_fuse_i,
		.programming_entry_pin_i, .serial_prog_mode_o, .adc_in_use_i, .jtag_enable_i,
		.tap_shift_i, .tdo_i, .port_g_bit0_write_strobe_i, .port_g_bit1_read_strobe_i,
		.port_g_bit2_latch_enable_i);
	board_model i_board_model (.ref_clk_i, .out_i(port_pin_o), .oe_i(port_pin_oe_o),
		.pu_i(port_pull_up_o), .ext_i(ext), .ext_en_i(ext_en), .level_o(port_pin_i));
	initial begin
		ref_clk_i = 1'b0;
		forever #4 ref_clk_i = ~ref_clk_i;
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// request holds until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [6:0] idx, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge ref_clk_i);
		avs_address <= {idx, 2'b00};
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= {24'h0, d};
		do @(posedge ref_clk_i); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr_reg(input logic [6:0] idx, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, idx, d, q);
	endtask
	task automatic rd_chk(input logic [6:0] idx, input logic [7:0] exp);
		logic [31:0] q;
		bus(1'b0, idx, 8'h00, q);
		check(q, {24'h0, exp});
	endtask
	task automatic reset_on();
		@(posedge ref_clk_i);
		rst_n_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
	endtask
	task automatic reset_off();
		@(posedge ref_clk_i);
		rst_n_i <= 1'b1;
	endtask
	task automatic t_ports();
		logic [7:0] m;
		for (int p = 0; p < NUM_PORTS; p++) begin
			m = PORT_MASK[p];
			wr_reg(DIR_IDX[p], 8'hff);
			wr_reg(LATCH_IDX[p], 8'h5a);
			@(negedge ref_clk_i);
			check(port_pin_oe_o[p], m);
			check(port_pin_o[p] & m, 8'h5a & m);
			// pin level needs two edges through the synchroniser
			repeat (2) @(posedge ref_clk_i);
			rd_chk(PIN_IDX[p], 8'h5a & m);
			wr_reg(DIR_IDX[p], 8'h00);
			@(negedge ref_clk_i);
			check(port_pull_up_o[p], 8'h5a & m);
			repeat (2) @(posedge ref_clk_i);
			rd_chk(PIN_IDX[p], ext[p] & m);
		end
	endtask
	task automatic t_refuse();
		wr_reg(LATCH_IDX[PORT_G], 8'hff);
		rd_chk(LATCH_IDX[PORT_G], 8'h1f);
		wr_reg(7'h7f, 8'hff);
		rd_chk(7'h7f, 8'h00);
		avs_byteenable <= 4'h0;
		wr_reg(DIR_IDX[PORT_B], 8'hff);
		avs_byteenable <= 4'h1;
		rd_chk(DIR_IDX[PORT_B], 8'h00);
	endtask
	task automatic t_reset();
		wr_reg(DIR_IDX[PORT_A], 8'hff);
		rst_n_i <= 1'b0;
		#1;
		check(port_pin_oe_o, 56'h0);
		@(posedge ref_clk_i);
		reset_off();
		rd_chk(DIR_IDX[PORT_A], 8'h00);
	endtask
	task automatic t_fport();
		wr_reg(DIR_IDX[PORT_F], 8'hff);
		adc_in_use_i <= 1'b1;
		@(negedge ref_clk_i);
		check(port_pin_oe_o[PORT_F], 8'h00);
		@(posedge ref_clk_i);
		adc_in_use_i <= 1'b0;
		jtag_enable_i <= 1'b1;
		@(negedge ref_clk_i);
		check(port_pin_oe_o[PORT_F], 8'h0f);
		@(posedge ref_clk_i);
		tap_shift_i <= 1'b1;
		tdo_i <= 1'b1;
		@(negedge ref_clk_i);
		check({port_pin_oe_o[PORT_F][TDO_BIT], port_pin_o[PORT_F][TDO_BIT]}, 2'h3);
		reset_on();
		check(port_pull_up_o[PORT_F] & JTAG_PU_MASK, JTAG_PU_MASK);
		check(port_pin_oe_o[PORT_F], 8'h00);
		@(posedge ref_clk_i);
		{jtag_enable_i, tap_shift_i} <= 2'h0;
		reset_off();
	endtask
	task automatic t_legacy();
		reset_on();
		@(posedge ref_clk_i);
		legacy_fuse_i <= 1'b1;
		repeat (8) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		check({port_pin_oe_o[PORT_C], port_pin_o[PORT_C]}, 16'hff00);
		check({port_pin_oe_o[PORT_G][2:0], port_pin_o[PORT_G][2:0]}, 6'h3b);
		reset_off();
		{port_g_bit2_latch_enable_i, port_g_bit1_read_strobe_i,
			port_g_bit0_write_strobe_i} <= 3'h5;
		wr_reg(DIR_IDX[PORT_F], 8'hff);
		wr_reg(DIR_IDX[PORT_G], 8'hff);
		wr_reg(LATCH_IDX[PORT_G], 8'h1f);
		@(negedge ref_clk_i);
		check(port_pin_oe_o[PORT_F], 8'h00);
		check(port_pin_o[PORT_G][2:0], 3'h5);
		check(port_pin_oe_o[PORT_G][4:3] | port_pull_up_o[PORT_G][4:3], 2'h0);
		rd_chk(STATUS_IDX, 8'h01);
		reset_on();
		@(posedge ref_clk_i);
		legacy_fuse_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		reset_off();
	endtask
	task automatic t_prog();
		reset_on();
		@(posedge ref_clk_i);
		programming_entry_pin_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		reset_off();
		repeat (2) @(negedge ref_clk_i);
		check(serial_prog_mode_o, 1'b1);
		rd_chk(STATUS_IDX, 8'h02);
		programming_entry_pin_i <= 1'b1;
		repeat (5) @(negedge ref_clk_i);
		check(serial_prog_mode_o, 1'b1);
		reset_on();
		reset_off();
		repeat (2) @(negedge ref_clk_i);
		check(serial_prog_mode_o, 1'b0);
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// the whole sequence needs well under a thousand cycles
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			num_errors++;
			conclude();
		end
	end
	initial begin
		{rst_n_i, avs_read, avs_write, legacy_fuse_i, adc_in_use_i} = 5'h0;
		{jtag_enable_i, tap_shift_i, tdo_i, port_g_bit0_write_strobe_i} = 4'h0;
		{port_g_bit1_read_strobe_i, port_g_bit2_latch_enable_i} = 2'h0;
		programming_entry_pin_i = 1'b1;
		avs_address = '0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h1;
		ext = 56'h1e_c3_78_e1_0f_a5_96;
		ext_en = {8'h1f, {6{8'hff}}};
		repeat (2) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		t_ports();
		t_refuse();
		t_reset();
		t_fport();
		t_legacy();
		t_prog();
		conclude();
	end
endmodule // tb_top
`default_nettype wire
